// *** hw/rbac_ctrl.sv ***
// Purpose: Burst activation, receive gating, lamps, report and command path
// Assumes: Decoders, serial transmitters and NVM reader are outside
// Notes: Rules of behaviour follow
// Behaviour
// - Carrier is main clock divided by 128
// - Carrier bursts 80 ms on, 30 ms off forever
// - One control line resets divider while off
// - HDX bits accepted only in off interval
// - FDX-B bits accepted only in on interval
// - Tag report sent on both serial outputs
// - Red lamp follows burst while scanning, except while a repeated tag flashes it
// - Green lamp pulses after valid tag
// - Repeated tag flashes both lamps near 9 Hz
// - Load and check config before bursts start
// - Commands accepted only when idle
// - Four commands: query, set, list, mode
// - Bad command answered with error code
`default_nettype none
module rbac_ctrl #(
	parameter int MS_CYCLES = rbac_pkg::MS_CYC,
	parameter logic [7:0] VERSION = 8'h11 // Arbitrary version value
) (
	input wire logic clk,
	input wire logic reset_n,
	output logic nvm_rd_req,
	input wire logic nvm_rd_done,
	input wire logic nvm_rd_ok,
	input wire logic [7:0] nvm_rd_data,
	output logic carrier_out,
	output logic burst_on,
	input wire logic hdx_clk_pin,
	input wire logic hdx_data_pin,
	input wire logic fdx_clk_pin,
	input wire logic fdx_data_pin,
	output logic hdx_bit,
	output logic hdx_bit_valid,
	output logic fdx_bit,
	output logic fdx_bit_valid,
	input wire logic tag_found,
	input wire logic [7:0] tag_byte,
	input wire logic tag_byte_valid,
	input wire logic tag_byte_last,
	output logic tag_byte_ready,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_arg,
	output logic cmd_ready,
	output logic [7:0] tx_byte,
	output logic tx232_valid,
	input wire logic tx232_ready,
	output logic tx422_valid,
	input wire logic tx422_ready,
	output logic lamp_red,
	output logic lamp_green,
	output logic [7:0] cfg_word,
	output logic [7:0] mode_word,
	output logic cfg_fault
);
	localparam int TW = $clog2(MS_CYCLES);
	localparam int CW = rbac_pkg::CARR_W;
	localparam int MW = rbac_pkg::MSC_W;
	localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);
	localparam logic [CW-1:0] CARR_LAST = CW'(rbac_pkg::CARR_DIV - 1);
	localparam logic [CW-1:0] CARR_HALF = CW'(rbac_pkg::CARR_DIV / 2 - 1);
	localparam logic [MW-1:0] ON_LAST = MW'(rbac_pkg::ON_MS - 1);
	localparam logic [MW-1:0] OFF_LAST = MW'(rbac_pkg::OFF_MS - 1);
	localparam logic [MW-1:0] GREEN_LEN = MW'(rbac_pkg::GREEN_MS);
	localparam logic [MW-1:0] REPEAT_LEN = MW'(rbac_pkg::REPEAT_MS);
	localparam logic [MW-1:0] FLASH_LAST = MW'(rbac_pkg::FLASH_HALF_MS - 1);
	localparam logic [MW-1:0] MS_ZERO = '0;
	localparam logic [1:0] FIFO_FULL = 2'(rbac_pkg::FIFO_DEPTH);
	// Elaboration check on the tick divider
	if (MS_CYCLES < 2 || MS_CYCLES > (1 << 20)) begin : g_bad_ms
		$error("MS_CYCLES out of range");
	end
	// Known command codes
	function automatic logic cmd_known(input logic [7:0] code);
		cmd_known = (code == rbac_pkg::CMD_QUERY) || (code == rbac_pkg::CMD_SET_CFG) ||
			(code == rbac_pkg::CMD_LIST) || (code == rbac_pkg::CMD_MODE);
	endfunction : cmd_known
	rbac_pkg::rbac_state_t state_q;
	logic [TW-1:0] tick_cnt_q;
	logic ms_tick;
	logic [MW-1:0] burst_cnt_q, green_cnt_q, recent_cnt_q, flash_cnt_q;
	logic burst_q, flashing_q, flash_ph_q;
	logic [CW-1:0] carr_cnt_q;
	logic [3:0] sync1_q, sync2_q;
	logic hdx_clk_prev_q, fdx_clk_prev_q;
	logic busy_q, busy, run;
	logic [1:0] resp_cnt_q;
	logic [7:0] resp_b0_q, resp_b1_q;
	logic [7:0] fifo_mem_q [rbac_pkg::FIFO_DEPTH];
	logic wr_ptr_q, rd_ptr_q;
	logic [1:0] fifo_cnt_q;
	logic fifo_full, push, pop, resp_take, cmd_take;
	logic [7:0] push_data;
	assign run = (state_q == rbac_pkg::ST_RUN);
	////////////////////////////////////////////////////////////////////////////
	// Start-up: fetch stored config, check it, then run
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= rbac_pkg::ST_LOAD;
		end else begin
			case (state_q)
				rbac_pkg::ST_LOAD: state_q <= rbac_pkg::ST_CHECK;
				rbac_pkg::ST_CHECK: if (nvm_rd_done) state_q <= rbac_pkg::ST_RUN;
				rbac_pkg::ST_RUN: state_q <= rbac_pkg::ST_RUN;
				default: state_q <= rbac_pkg::ST_LOAD;
			endcase
		end
	end
	assign nvm_rd_req = (state_q == rbac_pkg::ST_LOAD);
	// Config word: from memory when valid, else default; commands may rewrite
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg_word <= rbac_pkg::CFG_DEFAULT;
			cfg_fault <= 1'b0;
		end else if (state_q == rbac_pkg::ST_CHECK && nvm_rd_done) begin
			cfg_word <= nvm_rd_ok ? nvm_rd_data : rbac_pkg::CFG_DEFAULT;
			cfg_fault <= !nvm_rd_ok;
		end else if (cmd_take && cmd_code == rbac_pkg::CMD_SET_CFG) begin
			cfg_word <= cmd_arg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One millisecond enable counted on the main clock
	always_ff @(posedge clk) begin
		if (!reset_n || tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end
	assign ms_tick = (tick_cnt_q == TICK_LAST);
	// Burst phase: off interval first, then on, endlessly
	always_ff @(posedge clk) begin
		if (!reset_n || !run) begin
			burst_q <= 1'b0;
			burst_cnt_q <= '0;
		end else if (state_q == rbac_pkg::ST_RUN && ms_tick) begin
			if (burst_cnt_q == (burst_q ? ON_LAST : OFF_LAST)) begin
				burst_q <= !burst_q;
				burst_cnt_q <= '0;
			end else begin
				burst_cnt_q <= burst_cnt_q + 1'b1;
			end
		end
	end
	assign burst_on = burst_q;
	// Carrier divider, held in reset by the burst control line
	always_ff @(posedge clk) begin
		if (!reset_n || !burst_q) begin
			carr_cnt_q <= '0;
		end else begin
			carr_cnt_q <= carr_cnt_q + 1'b1;
		end
	end
	assign carrier_out = carr_cnt_q[CW-1];
	////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for the receive pins
	for (genvar i = 0; i < 4; i++) begin : g_sync
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
			end else begin
				sync1_q[i] <= (i == 0) ? hdx_clk_pin : (i == 1) ? hdx_data_pin :
					(i == 2) ? fdx_clk_pin : fdx_data_pin;
				sync2_q[i] <= sync1_q[i];
			end
		end
	end
	// Receive bits taken on the rising recovered clock, gated by phase
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hdx_clk_prev_q <= 1'b0;
			fdx_clk_prev_q <= 1'b0;
			hdx_bit <= 1'b0;
			hdx_bit_valid <= 1'b0;
			fdx_bit <= 1'b0;
			fdx_bit_valid <= 1'b0;
		end else begin
			hdx_clk_prev_q <= sync2_q[0];
			fdx_clk_prev_q <= sync2_q[2];
			hdx_bit_valid <= run && !burst_q && sync2_q[0] && !hdx_clk_prev_q;
			fdx_bit_valid <= run && burst_q && sync2_q[2] && !fdx_clk_prev_q;
			hdx_bit <= sync2_q[1];
			fdx_bit <= sync2_q[3];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lamp timers: green pulse, repeat window and flashing flag
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			green_cnt_q <= '0;
			recent_cnt_q <= '0;
			flashing_q <= 1'b0;
		end else if (run && tag_found) begin
			green_cnt_q <= GREEN_LEN;
			recent_cnt_q <= REPEAT_LEN;
			flashing_q <= (recent_cnt_q != MS_ZERO);
		end else begin
			if (ms_tick && green_cnt_q != MS_ZERO) green_cnt_q <= green_cnt_q - 1'b1;
			if (ms_tick && recent_cnt_q != MS_ZERO) recent_cnt_q <= recent_cnt_q - 1'b1;
			if (recent_cnt_q == MS_ZERO) flashing_q <= 1'b0;
		end
	end
	// Flash phase toggles every half period of the 9 Hz rate
	always_ff @(posedge clk) begin
		if (!reset_n || !flashing_q) begin
			flash_cnt_q <= '0;
			flash_ph_q <= 1'b1;
		end else if (ms_tick) begin
			if (flash_cnt_q == FLASH_LAST) begin
				flash_cnt_q <= '0;
				flash_ph_q <= !flash_ph_q;
			end else begin
				flash_cnt_q <= flash_cnt_q + 1'b1;
			end
		end
	end
	// Lamp outputs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lamp_red <= 1'b0;
			lamp_green <= 1'b0;
		end else begin
			lamp_red <= run && (flashing_q ? flash_ph_q : burst_q);
			lamp_green <= flashing_q ? flash_ph_q : (green_cnt_q != MS_ZERO);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Busy from tag detection until its report has left the buffer
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
		end else if (run && tag_found) begin
			busy_q <= 1'b1;
		end else if (tag_byte_valid && tag_byte_ready && tag_byte_last) begin
			busy_q <= 1'b0;
		end
	end
	assign busy = !run || busy_q || tag_byte_valid || fifo_cnt_q != 2'h0 || resp_cnt_q != 2'h0;
	assign cmd_ready = !busy;
	assign cmd_take = cmd_valid && cmd_ready;
	// Command decode and answer bytes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			resp_cnt_q <= 2'h0;
			resp_b0_q <= 8'h00;
			resp_b1_q <= 8'h00;
			mode_word <= rbac_pkg::MODE_DEFAULT;
		end else if (cmd_take) begin
			resp_cnt_q <= 2'h1;
			resp_b0_q <= rbac_pkg::RESP_ACK;
			if (!cmd_known(cmd_code)) begin
				resp_b0_q <= rbac_pkg::RESP_ERR;
			end else if (cmd_code == rbac_pkg::CMD_QUERY) begin
				resp_cnt_q <= 2'h2;
				resp_b0_q <= VERSION;
				resp_b1_q <= cfg_word;
			end else if (cmd_code == rbac_pkg::CMD_LIST) begin
				resp_b0_q <= rbac_pkg::RESP_LIST;
			end else if (cmd_code == rbac_pkg::CMD_MODE) begin
				mode_word <= cmd_arg;
			end
		end else if (resp_take) begin
			resp_cnt_q <= resp_cnt_q - 2'h1;
			resp_b0_q <= resp_b1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-entry buffer; tag bytes have priority over answers
	assign fifo_full = (fifo_cnt_q == FIFO_FULL);
	assign tag_byte_ready = !fifo_full;
	assign push = !fifo_full && (tag_byte_valid || resp_cnt_q != 2'h0);
	assign resp_take = push && !tag_byte_valid;
	assign push_data = tag_byte_valid ? tag_byte : resp_b0_q;
	assign tx232_valid = (fifo_cnt_q != 2'h0);
	assign tx422_valid = tx232_valid;
	assign pop = tx232_valid && tx232_ready && tx422_ready;
	assign tx_byte = fifo_mem_q[rd_ptr_q];
	always_ff @(posedge clk) begin
		if (push) fifo_mem_q[wr_ptr_q] <= push_data;
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			fifo_cnt_q <= 2'h0;
		end else begin
			if (push) wr_ptr_q <= !wr_ptr_q;
			if (pop) rd_ptr_q <= !rd_ptr_q;
			fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_carr_held: assert property (!burst_q |=> carr_cnt_q == '0)
		else $error("carrier divider not held while off");
	a_carr_rise: assert property (burst_q && carr_cnt_q == CARR_HALF |=> carrier_out)
		else $error("carrier did not rise at half count");
	a_carr_wrap: assert property (burst_q && carr_cnt_q == CARR_LAST ##1 burst_q
		|-> !carrier_out && carr_cnt_q == '0) else $error("carrier divider did not wrap");
	a_burst_end: assert property (run && ms_tick && burst_q && burst_cnt_q == ON_LAST
		|=> !burst_q) else $error("on interval wrong length");
	a_off_end: assert property (run && ms_tick && !burst_q && burst_cnt_q == OFF_LAST
		|=> burst_q) else $error("off interval wrong length");
	a_hdx_gate: assert property (hdx_bit_valid |-> !$past(burst_q))
		else $error("HDX bit accepted during on interval");
	a_fdx_gate: assert property (fdx_bit_valid |-> $past(burst_q))
		else $error("FDX-B bit accepted during off interval");
	a_tx_hold: assert property (tx232_valid && !pop |=> tx232_valid && tx422_valid
		&& $stable(tx_byte)) else $error("report byte dropped before both links took it");
	a_red_burst: assert property (run && !flashing_q |=> lamp_red == $past(burst_q))
		else $error("red lamp not following burst");
	a_green_pulse: assert property (run && tag_found && recent_cnt_q == MS_ZERO
		|=> ##1 lamp_green) else $error("green lamp missed tag");
	a_flash_both: assert property (flashing_q && $past(flashing_q)
		|-> lamp_red == lamp_green) else $error("lamps not flashing together");
	a_startup_quiet: assert property (!run |-> !burst_q && !carrier_out)
		else $error("burst before config checked");
	a_cmd_block: assert property (busy_q |-> !cmd_ready)
		else $error("command accepted while tag busy");
	a_err_reply: assert property (cmd_take && !cmd_known(cmd_code)
		|=> resp_b0_q == rbac_pkg::RESP_ERR && resp_cnt_q == 2'h1) else $error("no error answer");
endmodule : rbac_ctrl
`default_nettype wire

// *** pkg/rbac_pkg.sv ***
// Purpose: Shared constants for the tag reader burst activation controller
// Assumes: 125 MHz system clock
// Notes: All times in milliseconds are turned into ticks of a 1 ms enable
`default_nettype none
package rbac_pkg;
	// Clock and time base
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYC = CLK_HZ / MS_PER_S;
	// Carrier divider
	localparam int CARR_DIV = 128;
	localparam int CARR_W = $clog2(CARR_DIV);
	// Burst and lamp timing in milliseconds
	localparam int ON_MS = 80;
	localparam int OFF_MS = 30;
	localparam int GREEN_MS = 50;
	localparam int REPEAT_MS = 200;
	localparam int FLASH_HZ = 9;
	localparam int FLASH_HALF_MS = MS_PER_S / (2 * FLASH_HZ);
	localparam int MSC_W = 8;
	// Byte stream width and buffer depth
	localparam int DW = 8;
	localparam int FIFO_DEPTH = 2;
	// Command codes and answers
	localparam logic [7:0] CMD_QUERY = 8'h01;
	localparam logic [7:0] CMD_SET_CFG = 8'h02;
	localparam logic [7:0] CMD_LIST = 8'h03;
	localparam logic [7:0] CMD_MODE = 8'h04;
	localparam logic [7:0] RESP_ACK = 8'h06;
	localparam logic [7:0] RESP_ERR = 8'hEE;
	localparam logic [7:0] RESP_LIST = 8'h0F;
	localparam logic [7:0] CFG_DEFAULT = 8'h00;
	localparam logic [7:0] MODE_DEFAULT = 8'h00;
	// Start-up sequence
	typedef enum logic [1:0] {
		ST_LOAD = 2'h0,
		ST_CHECK = 2'h1,
		ST_RUN = 2'h3
	} rbac_state_t;
endpackage : rbac_pkg
`default_nettype wire

// *** tb/rbac_far_model.sv ***
// Purpose: Far-side model with the config memory and the two serial sinks
// Assumes: Outputs change by non-blocking assignment on the rising clock edge
// Notes: stall makes each sink drop its ready on a pattern of its own; bad_cfg spoils the config
`default_nettype none
module rbac_far_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic nvm_rd_req,
	output logic nvm_rd_done,
	output logic nvm_rd_ok,
	output logic [7:0] nvm_rd_data,
	input wire logic stall,
	input wire logic bad_cfg,
	output logic tx232_ready,
	output logic tx422_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_q = 8'h00;
	int wait_q = 0;
	////////////////////////////////////////////////////////////////////////////
	// Quiet start values
	initial begin
		nvm_rd_done = 1'b0;
		nvm_rd_ok = 1'b0;
		nvm_rd_data = 8'h00;
		tx232_ready = 1'b0;
		tx422_ready = 1'b0;
	end
	// Memory answers five cycles after a read; its bus keeps changing otherwise
	always @(posedge clk) begin
		cnt_q <= cnt_q + 8'h01;
		nvm_rd_done <= (wait_q == 1);
		nvm_rd_ok <= (wait_q == 1) ? !bad_cfg : cnt_q[0];
		nvm_rd_data <= (wait_q == 1) ? 8'h5A : cnt_q;
		wait_q <= !reset_n ? 0 : nvm_rd_req ? 5 : (wait_q > 0 ? wait_q - 1 : 0);
		tx232_ready <= !stall || cnt_q[0];
		tx422_ready <= !stall || cnt_q[1];
	end
endmodule : rbac_far_model
`default_nettype wire

// *** tb/rbac_ctrl_test.sv ***
// Purpose: Self-checking bench for the burst activation controller
// Assumes: One ms is shortened to 4 clock cycles
// Notes: Each scenario is one task that judges its own results
`default_nettype none
module rbac_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] VER = 8'h3D; // Arbitrary version value
	logic clk = 1'b0, reset_n = 1'b0, stall = 1'b0, bad_cfg = 1'b0;
	logic nvm_rd_req, nvm_rd_done, nvm_rd_ok, carrier_out, burst_on, hdx_bit, hdx_bit_valid;
	logic fdx_bit, fdx_bit_valid, tag_byte_ready, cmd_ready, tx232_valid, tx422_valid;
	logic tx232_ready, tx422_ready, lamp_red, lamp_green, cfg_fault;
	logic [7:0] nvm_rd_data, tx_byte, cfg_word, mode_word;
	logic hdx_clk_pin = 1'b0, hdx_data_pin = 1'b0, fdx_clk_pin = 1'b0, fdx_data_pin = 1'b0;
	logic tag_found = 1'b0, tag_byte_valid = 1'b0, tag_byte_last = 1'b0, cmd_valid = 1'b0;
	logic [7:0] tag_byte = 8'h00, cmd_code = 8'h00, cmd_arg = 8'h00;
	int bad_count = 0, checked = 0;
	logic [7:0] got_q[$];
	////////////////////////////////////////////////////////////////////////////
	// Design and far side
	rbac_ctrl #(.MS_CYCLES(4), .VERSION(VER)) dut (.clk(clk), .reset_n(reset_n),
		.nvm_rd_req(nvm_rd_req), .nvm_rd_done(nvm_rd_done), .nvm_rd_ok(nvm_rd_ok),
		.nvm_rd_data(nvm_rd_data), .carrier_out(carrier_out), .burst_on(burst_on),
		.hdx_clk_pin(hdx_clk_pin), .hdx_data_pin(hdx_data_pin), .fdx_clk_pin(fdx_clk_pin),
		.fdx_data_pin(fdx_data_pin), .hdx_bit(hdx_bit), .hdx_bit_valid(hdx_bit_valid),
		.fdx_bit(fdx_bit), .fdx_bit_valid(fdx_bit_valid), .tag_found(tag_found),
		.tag_byte(tag_byte), .tag_byte_valid(tag_byte_valid), .tag_byte_last(tag_byte_last),
		.tag_byte_ready(tag_byte_ready), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .tx_byte(tx_byte), .tx232_valid(tx232_valid),
		.tx232_ready(tx232_ready), .tx422_valid(tx422_valid), .tx422_ready(tx422_ready),
		.lamp_red(lamp_red), .lamp_green(lamp_green), .cfg_word(cfg_word),
		.mode_word(mode_word), .cfg_fault(cfg_fault));
	rbac_far_model far (.clk(clk), .reset_n(reset_n), .nvm_rd_req(nvm_rd_req),
		.nvm_rd_done(nvm_rd_done), .nvm_rd_ok(nvm_rd_ok), .nvm_rd_data(nvm_rd_data),
		.stall(stall), .bad_cfg(bad_cfg), .tx232_ready(tx232_ready),
		.tx422_ready(tx422_ready));
	////////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		forever #4 clk = ~clk;
	end
	// Collect bytes that leave on both links
	always @(posedge clk) begin
		if (reset_n && tx232_valid && tx232_ready && tx422_ready) got_q.push_back(tx_byte);
		if (reset_n && tx232_valid !== tx422_valid) chk("tx valid pair", 1, 0);
	end
	////////////////////////////////////////////////////////////////////////////
	task final_report();
		$display("Counts: checked %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic wait_for(ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim && s !== v; i++) begin
			@(posedge clk);
			#1;
		end
		if (s !== v) begin
			chk("wait bound", 1, 0);
			final_report();
		end
	endtask : wait_for
	task automatic wait_got(input int n);
		for (int i = 0; i < 400 && got_q.size() < n; i++) begin
			@(posedge clk);
			#1;
		end
		if (got_q.size() < n) begin
			chk("bytes received", n, got_q.size());
			final_report();
		end
	endtask : wait_got
	task automatic send_cmd(input logic [7:0] c, input logic [7:0] a);
		wait_for(cmd_ready, 1'b1, 400);
		cmd_code = c;
		cmd_arg = a;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
	endtask : send_cmd
	// Holds the byte until ready was high at an edge; returns 1 if refused
	task automatic send_tag(input logic [7:0] b, input logic l, output logic refused);
		logic r;
		refused = 1'b0;
		tag_byte = b;
		tag_byte_last = l;
		tag_byte_valid = 1'b1;
		for (int i = 0; i < 400; i++) begin
			r = tag_byte_ready;
			refused |= !r;
			@(posedge clk);
			#1;
			if (r) break;
		end
		if (!r) chk("tag byte accept", 1, 0);
	endtask : send_tag
	task automatic pin_try(ref logic pin, ref logic vld, input logic acc, input string nm);
		int at = 0;
		pin = 1'b1;
		for (int k = 1; k <= 8; k++) begin
			@(posedge clk);
			#1;
			if (vld === 1'b1 && at == 0) at = k;
			if (k == 4) pin = 1'b0;
		end
		chk(nm, acc ? 3 : 0, at);
	endtask : pin_try
	////////////////////////////////////////////////////////////////////////////
	task automatic t_start();
		wait_for(nvm_rd_req, 1'b1, 10);
		chk("burst before config", 0, burst_on);
		wait_for(nvm_rd_done, 1'b1, 20);
		chk("burst at config", 0, burst_on);
		wait_for(cmd_ready, 1'b1, 20);
		chk("cfg_word", 8'h5A, cfg_word);
		chk("cfg_fault", 0, cfg_fault);
		$display("start-up test done");
	endtask : t_start
	task automatic t_burst();
		int n = 0;
		int r1 = 0;
		int r2 = 0;
		logic pc = 1'b0;
		logic pb = 1'b1;
		logic bad = 1'b0;
		wait_for(burst_on, 1'b1, 600);
		while (burst_on === 1'b1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
			if (carrier_out === 1'b1 && !pc) begin
				r1 = r2;
				r2 = n;
			end
			pc = carrier_out;
			if (lamp_red !== pb) bad = 1'b1;
			pb = burst_on;
		end
		chk("on length", 320, n);
		chk("carrier period", 128, r2 - r1);
		n = 0;
		while (burst_on === 1'b0 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
			if (pb === 1'b0 && carrier_out !== 1'b0) bad = 1'b1;
			if (lamp_red !== pb) bad = 1'b1;
			pb = burst_on;
		end
		chk("off length", 120, n);
		chk("red lamp and carrier gating", 0, bad);
		$display("burst test done");
	endtask : t_burst
	task automatic t_gate();
		wait_for(burst_on, 1'b0, 600);
		hdx_data_pin = 1'b1;
		fdx_data_pin = 1'b1;
		pin_try(hdx_clk_pin, hdx_bit_valid, 1'b1, "hdx while off");
		chk("hdx bit", 1, hdx_bit);
		pin_try(fdx_clk_pin, fdx_bit_valid, 1'b0, "fdx while off");
		wait_for(burst_on, 1'b1, 300);
		pin_try(hdx_clk_pin, hdx_bit_valid, 1'b0, "hdx while on");
		pin_try(fdx_clk_pin, fdx_bit_valid, 1'b1, "fdx while on");
		chk("fdx bit", 1, fdx_bit);
		$display("receive gating test done");
	endtask : t_gate
	task automatic t_cmd();
		logic [7:0] code[7] = '{rbac_pkg::CMD_QUERY, rbac_pkg::CMD_SET_CFG, rbac_pkg::CMD_QUERY,
			rbac_pkg::CMD_LIST, rbac_pkg::CMD_MODE, 8'h55, 8'h00};
		logic [7:0] arg[7] = '{8'h00, 8'hA5, 8'h00, 8'h00, 8'h3C, 8'h00, 8'h00};
		logic [7:0] ans[7] = '{VER, rbac_pkg::RESP_ACK, VER, rbac_pkg::RESP_LIST,
			rbac_pkg::RESP_ACK, rbac_pkg::RESP_ERR, rbac_pkg::RESP_ERR};
		for (int i = 0; i < 7; i++) begin
			got_q.delete();
			stall = i[0];
			send_cmd(code[i], arg[i]);
			wait_got(code[i] == rbac_pkg::CMD_QUERY ? 2 : 1);
			chk("answer byte", ans[i], got_q[0]);
			if (i == 0 || i == 2) chk("query cfg byte", i == 0 ? 8'h5A : 8'hA5, got_q[1]);
		end
		chk("cfg_word after set", 8'hA5, cfg_word);
		chk("mode_word after set", 8'h3C, mode_word);
		stall = 1'b0;
		$display("command test done");
	endtask : t_cmd
	task automatic t_tag();
		int at = 0;
		logic rf;
		logic any = 1'b0;
		wait_for(cmd_ready, 1'b1, 100);
		got_q.delete();
		stall = 1'b1;
		tag_found = 1'b1;
		for (int k = 1; k <= 4; k++) begin
			@(posedge clk);
			#1;
			tag_found = 1'b0;
			if (lamp_green === 1'b1 && at == 0) at = k;
		end
		chk("green delay", 2, at);
		for (int j = 0; j < 4; j++) begin
			chk("cmd_ready while busy", 0, cmd_ready);
			send_tag(8'hC1 + j[7:0], j == 3, rf);
			any |= rf;
		end
		tag_byte_valid = 1'b0;
		tag_byte_last = 1'b0;
		chk("buffer refusal", 1, any);
		stall = 1'b0;
		wait_got(4);
		for (int j = 0; j < 4; j++) chk("report byte", 8'hC1 + j[7:0], got_q[j]);
		wait_for(cmd_ready, 1'b1, 100);
		$display("tag report test done");
	endtask : t_tag
	task automatic t_flash();
		int tog = 0;
		logic rf;
		logic bad = 1'b0;
		logic pg;
		got_q.delete();
		tag_found = 1'b1;
		@(posedge clk);
		#1;
		tag_found = 1'b0;
		send_tag(8'h77, 1'b1, rf);
		tag_byte_valid = 1'b0;
		tag_byte_last = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		pg = lamp_green;
		for (int k = 0; k < 300; k++) begin
			@(posedge clk);
			#1;
			if (lamp_red !== lamp_green) bad = 1'b1;
			if (lamp_green !== pg) tog++;
			pg = lamp_green;
		end
		chk("lamps apart", 0, bad);
		chk("lamp flashing", 1, tog > 0);
		wait_got(1);
		chk("repeat report byte", 8'h77, got_q[0]);
		wait_for(cmd_ready, 1'b1, 100);
		$display("repeat flash test done");
	endtask : t_flash
	// Mid-run reset with a spoiled stored config
	task automatic t_reset();
		bad_cfg = 1'b1;
		reset_n = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		reset_n = 1'b1;
		chk("burst after reset", 0, burst_on);
		chk("red after reset", 0, lamp_red);
		chk("cmd_ready after reset", 0, cmd_ready);
		wait_for(cmd_ready, 1'b1, 40);
		chk("default cfg_word", rbac_pkg::CFG_DEFAULT, cfg_word);
		chk("cfg_fault", 1, cfg_fault);
		chk("mode_word after reset", rbac_pkg::MODE_DEFAULT, mode_word);
		$display("reset and bad config test done");
	endtask : t_reset
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1;
		reset_n = 1'b1;
		t_start();
		t_burst();
		t_gate();
		t_cmd();
		t_tag();
		t_flash();
		t_reset();
		final_report();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		chk("run time", 0, 1);
		final_report();
	end
endmodule : rbac_ctrl_test
`default_nettype wire
